// ### rtl/dtc_pkg.sv
package dtc_pkg;

    // channel count and register bus address width
    localparam int          DTC_NCH        = 32;
    localparam int          DTC_AW         = 12;

    // register byte offsets
    localparam logic [11:0] DTC_OFS_STATUS   = 12'h000;
    localparam logic [11:0] DTC_OFS_BASE     = 12'h004;
    localparam logic [11:0] DTC_OFS_EN_SET   = 12'h008;
    localparam logic [11:0] DTC_OFS_EN_CLR   = 12'h00C;
    localparam logic [11:0] DTC_OFS_BO_SET   = 12'h010;
    localparam logic [11:0] DTC_OFS_BO_CLR   = 12'h014;
    localparam logic [11:0] DTC_OFS_PRIO_SET = 12'h018;
    localparam logic [11:0] DTC_OFS_PRIO_CLR = 12'h01C;
    localparam logic [11:0] DTC_OFS_SWREQ    = 12'h020;
    localparam logic [11:0] DTC_OFS_ALT      = 12'h024;

    // control table layout: alternate half, structure stride, words inside
    localparam logic [31:0] DTC_TBL_ALT_OFS = 32'h0000_0200;
    localparam logic [31:0] DTC_TBL_STRIDE  = 32'h0000_0010;
    localparam logic [31:0] DTC_SE_SRC      = 32'h0000_0000;
    localparam logic [31:0] DTC_SE_DST      = 32'h0000_0004;
    localparam logic [31:0] DTC_SE_CTL      = 32'h0000_0008;
    localparam int          DTC_BASE_LSB    = 10;
    localparam int          DTC_BASE_W      = 22;

    // control word field positions
    localparam int          DTC_CW_MODE_LSB  = 0;
    localparam int          DTC_CW_MODE_W    = 3;
    localparam int          DTC_CW_BURST_BIT = 3;
    localparam int          DTC_CW_CNT_LSB   = 4;
    localparam int          DTC_CW_CNT_W     = 10;
    localparam int          DTC_CW_ARB_LSB   = 14;
    localparam int          DTC_CW_ARB_W     = 4;
    localparam int          DTC_CW_SSIZE_LSB = 24;
    localparam int          DTC_CW_SINC_LSB  = 26;
    localparam int          DTC_CW_DSIZE_LSB = 28;
    localparam int          DTC_CW_DINC_LSB  = 30;

    // mode field encodings
    localparam logic [2:0]  DTC_MODE_STOP  = 3'h0;
    localparam logic [2:0]  DTC_MODE_BASIC = 3'h1;
    localparam logic [2:0]  DTC_MODE_AUTO  = 3'h2;
    localparam logic [2:0]  DTC_MODE_PP    = 3'h3;

    // size and increment codes, largest arbitration exponent
    localparam logic [1:0]  DTC_INC_NONE  = 2'h3;
    localparam logic [1:0]  DTC_SIZE_WORD = 2'h2;
    localparam logic [3:0]  DTC_ARB_MAXLG = 4'hA;

    typedef enum logic [2:0] {
        S_IDLE,
        S_RD_SRC,
        S_RD_DST,
        S_RD_CTL,
        S_CHECK,
        S_RD_DATA,
        S_WR_DATA,
        S_WB_CTL
    } dtc_fsm_type;

    // memory master request group
    typedef struct packed {
        logic        req;
        logic        we;
        logic [1:0]  size;
        logic [31:0] addr;
        logic [31:0] wdata;
    } dtc_mem_req_type;

    // whole state of the engine
    typedef struct packed {
        dtc_fsm_type     st;
        logic [31:0]     en;
        logic [31:0]     bonly;
        logic [31:0]     prio;
        logic [31:0]     alt;
        logic [31:0]     swp;
        logic [31:0]     autoa;
        logic [31:0]     done;
        logic [21:0]     base;
        logic [4:0]      ch;
        logic            is_alt;
        logic            burst_req;
        logic            fin;
        logic [31:0]     src;
        logic [31:0]     dst;
        logic [31:0]     ctl;
        logic [31:0]     data;
        logic [10:0]     left;
        dtc_mem_req_type mem;
        logic            pready;
        logic            pslverr;
        logic [31:0]     prdata;
    } dtc_regs_type;

    localparam dtc_regs_type DTC_REGS_RST = '0;

endpackage

// ### rtl/dtc_arbiter.sv
`timescale 1ns/10ps
module dtc_arbiter
    import dtc_pkg::*;
(
    input  wire logic [31:0] req,
    input  wire logic [31:0] hi,
    output logic             valid,
    output logic [4:0]       idx
);

    // scan downward so the lowest requesting number wins within a level
    always_comb
    begin
        logic [4:0] hidx;
        logic [4:0] lidx;
        hidx = 5'h00;
        lidx = 5'h00;
        for (int i = DTC_NCH - 1; i >= 0; i--)
        begin
            if (req[i] && hi[i])
            begin
                hidx = 5'(i);
            end
            if (req[i])
            begin
                lidx = 5'(i);
            end
        end
        // high level beats every default channel
        valid = |req;
        idx   = (|(req & hi)) ? hidx : lidx;
    end

endmodule

// ### rtl/dtc_engine.sv
// Decided for this implementation: the register addresses and the APB register port.
`timescale 1ns/10ps
module dtc_engine
    import dtc_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              resetn,
    input  wire logic              clk_en,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic [31:0]       req_single,
    input  wire logic [31:0]       req_burst,
    output dtc_mem_req_type        mem_out,
    input  wire logic              mem_ack,
    input  wire logic [31:0]       mem_rdata,
    output logic [31:0]            chan_done
);

    dtc_regs_type r;           // registered state
    dtc_regs_type n;           // next state
    logic [31:0]  elig;        // enabled channels with a live request
    logic         arb_valid;   // some channel eligible
    logic [4:0]   arb_idx;     // winning channel
    logic [2:0]   ctl_mode;    // mode field of fetched control word
    logic [9:0]   ctl_cnt;     // items remaining minus one
    logic [3:0]   ctl_arb;     // arbitration size exponent
    logic         ctl_stop;    // mode field does not name a live mode
    logic         multi;       // service moves a whole burst
    logic [10:0]  nitems;      // items for this service
    logic [10:0]  arb_items;   // arbitration size in items
    logic [31:0]  src_item;    // current source item address
    logic [31:0]  dst_item;    // current destination item address
    logic [31:0]  wb_word;     // control word to write back
    logic         apb_wr;      // register write commits this edge
    logic         en_set_wr;   // enable set being written
    logic         alt_cur;     // structure select of current channel

    // peripheral lines are same-clock logic, so no synchroniser
    assign elig = r.en & (req_burst | (req_single & ~r.bonly) | r.swp | r.autoa);

    dtc_arbiter u_arb
    (
        .req   (elig),
        .hi    (r.prio),
        .valid (arb_valid),
        .idx   (arb_idx)
    );

    // control word field extraction
    assign ctl_mode  = r.ctl[DTC_CW_MODE_LSB +: DTC_CW_MODE_W];
    assign ctl_cnt   = r.ctl[DTC_CW_CNT_LSB +: DTC_CW_CNT_W];
    assign ctl_arb   = (r.ctl[DTC_CW_ARB_LSB +: DTC_CW_ARB_W] > DTC_ARB_MAXLG) ?
                       DTC_ARB_MAXLG : r.ctl[DTC_CW_ARB_LSB +: DTC_CW_ARB_W];
    assign ctl_stop  = (ctl_mode == DTC_MODE_STOP) || (ctl_mode > DTC_MODE_PP);
    assign arb_items = 11'h001 << ctl_arb;
    // a burst request, or an auto transfer under way, moves a burst
    assign multi     = r.burst_req || (ctl_mode == DTC_MODE_AUTO) || r.autoa[r.ch];
    assign nitems    = (arb_items < (11'(ctl_cnt) + 11'h001)) ?
                       arb_items : (11'(ctl_cnt) + 11'h001);
    assign alt_cur   = r.alt[r.ch];

    // item address counts back from the inclusive end pointer
    assign src_item = (r.ctl[DTC_CW_SINC_LSB +: 2] == DTC_INC_NONE) ? r.src :
                      r.src - (32'(ctl_cnt) << r.ctl[DTC_CW_SINC_LSB +: 2]);
    assign dst_item = (r.ctl[DTC_CW_DINC_LSB +: 2] == DTC_INC_NONE) ? r.dst :
                      r.dst - (32'(ctl_cnt) << r.ctl[DTC_CW_DINC_LSB +: 2]);

    // last writeback leaves count 0 and mode Stop
    always_comb
    begin
        wb_word = r.ctl;
        if (r.fin)
        begin
            wb_word[DTC_CW_CNT_LSB +: DTC_CW_CNT_W]   = 10'h000;
            wb_word[DTC_CW_MODE_LSB +: DTC_CW_MODE_W] = DTC_MODE_STOP;
        end
    end

    // writes take effect at the edge where pready is seen high
    assign apb_wr    = psel && penable && r.pready && pwrite && !r.pslverr;
    assign en_set_wr = apb_wr && (paddr == DTC_OFS_EN_SET);

    // next-state process: register file and transfer sequencer
    always_comb
    begin
        logic [31:0] hw_clr;
        logic [31:0] grant_clr;
        logic        hit;
        logic [31:0] rdv;
        logic [31:0] tbl;
        hw_clr    = 32'h0000_0000;
        grant_clr = 32'h0000_0000;
        hit       = 1'b1;
        rdv       = 32'h0000_0000;
        n         = r;
        n.done    = 32'h0000_0000;
        // structure base: table base plus half plus channel stride
        tbl       = {r.base, 10'h000} + (r.is_alt ? DTC_TBL_ALT_OFS : 32'h0000_0000)
                    + (32'(r.ch) * DTC_TBL_STRIDE);

        // read decode, unmapped offsets answer with an error
        case (paddr)
            DTC_OFS_STATUS:   rdv = {22'h0, r.is_alt, (r.st != S_IDLE), 3'h0, r.ch};
            DTC_OFS_BASE:     rdv = {r.base, 10'h000};
            DTC_OFS_EN_SET,
            DTC_OFS_EN_CLR:   rdv = r.en;
            DTC_OFS_BO_SET,
            DTC_OFS_BO_CLR:   rdv = r.bonly;
            DTC_OFS_PRIO_SET,
            DTC_OFS_PRIO_CLR: rdv = r.prio;
            DTC_OFS_SWREQ:    rdv = r.swp;
            DTC_OFS_ALT:      rdv = r.alt;
            default:          hit = 1'b0;
        endcase

        // access phase answered one cycle after it opens
        n.pready = 1'b0;
        if (psel && penable && !r.pready)
        begin
            n.pready  = 1'b1;
            n.pslverr = !hit;
            n.prdata  = hit ? rdv : 32'h0000_0000;
        end

        case (r.st)
            // pick the best eligible channel
            S_IDLE:
            begin
                if (arb_valid)
                begin
                    n.ch        = arb_idx;
                    n.is_alt    = r.alt[arb_idx];
                    n.burst_req = req_burst[arb_idx];
                    grant_clr   = 32'h0000_0001 << arb_idx;
                    n.st        = S_RD_SRC;
                end
            end
            // fetch the three live words of the structure
            S_RD_SRC, S_RD_DST, S_RD_CTL:
            begin
                if (!r.mem.req)
                begin
                    n.mem.req  = 1'b1;
                    n.mem.we   = 1'b0;
                    n.mem.size = DTC_SIZE_WORD;
                    n.mem.addr = tbl + ((r.st == S_RD_SRC) ? DTC_SE_SRC :
                                        (r.st == S_RD_DST) ? DTC_SE_DST : DTC_SE_CTL);
                end
                else if (mem_ack)
                begin
                    n.mem.req = 1'b0;
                    if (r.st == S_RD_SRC)
                    begin
                        n.src = mem_rdata;
                        n.st  = S_RD_DST;
                    end
                    else if (r.st == S_RD_DST)
                    begin
                        n.dst = mem_rdata;
                        n.st  = S_RD_CTL;
                    end
                    else
                    begin
                        n.ctl = mem_rdata;
                        n.st  = S_CHECK;
                    end
                end
            end
            // decide what this service moves
            S_CHECK:
            begin
                if (ctl_stop)
                begin
                    hw_clr[r.ch]  = 1'b1;
                    n.autoa[r.ch] = 1'b0;
                    n.st          = S_IDLE;
                end
                else if (r.ctl[DTC_CW_BURST_BIT] && !multi)
                begin
                    // word asks for bursts only: drop the single request
                    n.st = S_IDLE;
                end
                else
                begin
                    n.left = multi ? nitems : 11'h001;
                    if (ctl_mode == DTC_MODE_AUTO)
                    begin
                        n.autoa[r.ch] = 1'b1;
                    end
                    n.st = S_RD_DATA;
                end
            end
            // read one item from the source
            S_RD_DATA:
            begin
                if (!r.mem.req)
                begin
                    n.mem.req  = 1'b1;
                    n.mem.we   = 1'b0;
                    n.mem.size = r.ctl[DTC_CW_SSIZE_LSB +: 2];
                    n.mem.addr = src_item;
                end
                else if (mem_ack)
                begin
                    n.mem.req = 1'b0;
                    n.data    = mem_rdata;
                    n.st      = S_WR_DATA;
                end
            end
            // write it to the destination and count it
            S_WR_DATA:
            begin
                if (!r.mem.req)
                begin
                    n.mem.req   = 1'b1;
                    n.mem.we    = 1'b1;
                    n.mem.size  = r.ctl[DTC_CW_DSIZE_LSB +: 2];
                    n.mem.addr  = dst_item;
                    n.mem.wdata = r.data;
                end
                else if (mem_ack)
                begin
                    n.mem.req = 1'b0;
                    n.mem.we  = 1'b0;
                    if (ctl_cnt == 10'h000)
                    begin
                        n.fin = 1'b1;
                        n.st  = S_WB_CTL;
                    end
                    else
                    begin
                        n.fin                                  = 1'b0;
                        n.ctl[DTC_CW_CNT_LSB +: DTC_CW_CNT_W] = ctl_cnt - 10'h001;
                        n.left                                 = r.left - 11'h001;
                        // burst spent: write back, then re-arbitrate
                        n.st = (r.left == 11'h001) ? S_WB_CTL : S_RD_DATA;
                    end
                end
            end
            // only the control word goes back, pointers stay untouched
            S_WB_CTL:
            begin
                if (!r.mem.req)
                begin
                    n.mem.req   = 1'b1;
                    n.mem.we    = 1'b1;
                    n.mem.size  = DTC_SIZE_WORD;
                    n.mem.addr  = tbl + DTC_SE_CTL;
                    n.mem.wdata = wb_word;
                end
                else if (mem_ack)
                begin
                    n.mem.req = 1'b0;
                    n.mem.we  = 1'b0;
                    if (r.fin)
                    begin
                        n.done[r.ch]  = 1'b1;
                        n.autoa[r.ch] = 1'b0;
                        if (ctl_mode == DTC_MODE_PP)
                        begin
                            // stay enabled and swap to the other structure
                            n.alt[r.ch] = ~r.alt[r.ch];
                        end
                        else
                        begin
                            hw_clr[r.ch] = 1'b1;
                        end
                    end
                    n.fin = 1'b0;
                    n.st  = S_IDLE;
                end
            end
            default:
            begin
                n.st = S_IDLE;
            end
        endcase

        // set-style and clear-style writes, software set beats hardware clear
        if (apb_wr && (paddr == DTC_OFS_BASE))
        begin
            n.base = pwdata[DTC_BASE_LSB +: DTC_BASE_W];
        end
        n.en = (r.en & ~hw_clr
                & ~((apb_wr && (paddr == DTC_OFS_EN_CLR)) ? pwdata : 32'h0000_0000))
               | (en_set_wr ? pwdata : 32'h0000_0000);
        n.bonly = (r.bonly & ~((apb_wr && (paddr == DTC_OFS_BO_CLR)) ? pwdata : 32'h0000_0000))
                  | ((apb_wr && (paddr == DTC_OFS_BO_SET)) ? pwdata : 32'h0000_0000);
        n.prio = (r.prio & ~((apb_wr && (paddr == DTC_OFS_PRIO_CLR)) ? pwdata : 32'h0000_0000))
                 | ((apb_wr && (paddr == DTC_OFS_PRIO_SET)) ? pwdata : 32'h0000_0000);
        // a new software request in the grant cycle is kept
        n.swp = (r.swp & ~grant_clr)
                | ((apb_wr && (paddr == DTC_OFS_SWREQ)) ? pwdata : 32'h0000_0000);
    end

    // single state register, frozen while clk_en is low
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            r <= DTC_REGS_RST;
        end
        else if (clk_en)
        begin
            r <= n;
        end
    end

    // every output straight from the state register
    assign prdata    = r.prdata;
    assign pready    = r.pready;
    assign pslverr   = r.pslverr;
    assign mem_out   = r.mem;
    assign chan_done = r.done;

    // burst length never beyond arbitration size or remaining items
    burst_bound_a: assert property (@(posedge clk) disable iff (!resetn)
        (r.st == S_RD_DATA) |-> (r.left != 11'h000 && r.left <= arb_items
                                 && r.left <= (11'(ctl_cnt) + 11'h001)))
        else $error("burst length out of bounds");

    // burst-only channel granted only for a burst, software or auto request
    burst_only_a: assert property (@(posedge clk) disable iff (!resetn)
        (r.st == S_IDLE && arb_valid && r.bonly[arb_idx])
        |-> (req_burst[arb_idx] || r.swp[arb_idx] || r.autoa[arb_idx]))
        else $error("single request served on burst-only channel");

    // structure fetch lands on the right table slot
    table_slot_a: assert property (@(posedge clk) disable iff (!resetn)
        (r.st == S_RD_SRC && r.mem.req) |-> (r.mem.addr[9:0] == {alt_cur, r.ch, 4'h0}))
        else $error("structure address wrong");

    // structure writes only ever hit the control word
    ptr_untouched_a: assert property (@(posedge clk) disable iff (!resetn)
        (r.mem.req && r.mem.we && r.st == S_WB_CTL) |-> (r.mem.addr[3:0] == 4'h8))
        else $error("engine wrote an end pointer");

    // final writeback shows count 0 and mode Stop
    count_clear_a: assert property (@(posedge clk) disable iff (!resetn)
        (r.st == S_WB_CTL && r.fin && r.mem.req)
        |-> (r.mem.wdata[DTC_CW_CNT_LSB +: DTC_CW_CNT_W] == 10'h000
             && r.mem.wdata[DTC_CW_MODE_LSB +: DTC_CW_MODE_W] == DTC_MODE_STOP))
        else $error("completion writeback not zero and Stop");

    // grant only to an enabled channel
    enable_gate_a: assert property (@(posedge clk) disable iff (!resetn)
        (r.st == S_IDLE && arb_valid) |-> r.en[arb_idx])
        else $error("disabled channel granted");

    // completion of a one-shot mode disables the channel
    auto_disable_a: assert property (@(posedge clk) disable iff (!resetn)
        (clk_en && r.st == S_WB_CTL && r.mem.req && mem_ack && r.fin
         && ctl_mode != DTC_MODE_PP && !en_set_wr)
        |=> (!r.en[r.ch] && r.done[r.ch] && r.st == S_IDLE))
        else $error("channel still enabled after completion");

    // Stop mode moves nothing and disables
    stop_disable_a: assert property (@(posedge clk) disable iff (!resetn)
        (clk_en && r.st == S_CHECK && ctl_stop && !en_set_wr)
        |=> (r.st == S_IDLE && !r.en[r.ch] && !r.mem.req))
        else $error("Stop mode did not disable channel");

    // lone single request moves exactly one item
    single_item_a: assert property (@(posedge clk) disable iff (!resetn)
        (clk_en && r.st == S_CHECK && !ctl_stop && !multi && !r.ctl[DTC_CW_BURST_BIT])
        |=> (r.st == S_RD_DATA && r.left == 11'h001))
        else $error("single request moved more than one item");

    // ping-pong completion swaps structure and pulses the event
    pp_switch_a: assert property (@(posedge clk) disable iff (!resetn)
        (clk_en && r.st == S_WB_CTL && r.mem.req && mem_ack && r.fin
         && ctl_mode == DTC_MODE_PP)
        |=> (r.done[r.ch] && alt_cur != $past(alt_cur)))
        else $error("ping-pong switch missing");

endmodule

// ### testbench/dtc_mem_model.sv
`timescale 1ns/10ps
// word store; answers each request once, at once or after 3 stalls
module dtc_mem_model
    import dtc_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       slow,
    input  dtc_mem_req_type mem_out,
    output logic            mem_ack,
    output logic [31:0]     mem_rdata
);
    logic [31:0] mem [logic [31:0]]; // sparse memory
    logic [1:0]  wt = 2'h0;          // stall count
    initial mem_ack = 1'b0;
    initial mem_rdata = 32'h0;
    // idle data line toggles so a stale word never passes
    always @(posedge clk)
    begin
        mem_ack <= 1'b0;
        mem_rdata <= ~mem_rdata;
        if (mem_out.req && !mem_ack)
            wt <= wt + 2'h1;
        if (mem_out.req && !mem_ack && (wt == 2'h3 || !slow))
        begin
            mem_ack <= 1'b1;
            wt <= 2'h0;
            if (mem_out.we)
                mem[mem_out.addr] = mem_out.wdata;
            else
                mem_rdata <= mem[mem_out.addr];
        end
    end
endmodule

// ### testbench/dma_channel_transfer_control_test.sv
`timescale 1ns/10ps
module dma_channel_transfer_control_test;
    import dtc_pkg::*;
    logic            clk, resetn, psel, penable, pwrite, pready, pslverr, mem_ack, slow, err;
    logic [11:0]     paddr;
    logic [31:0]     pwdata, prdata, mem_rdata, chan_done, req_single, req_burst, rd, cta, old;
    dtc_mem_req_type mem_out;
    int              fails, tests_run, seed, ch, k;
    dtc_engine i_dtc_engine (.clk(clk), .resetn(resetn), .clk_en(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .req_single(req_single), .req_burst(req_burst),
        .mem_out(mem_out), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .chan_done(chan_done));
    dtc_mem_model i_mem (.clk(clk), .slow(slow), .mem_out(mem_out), .mem_ack(mem_ack),
        .mem_rdata(mem_rdata));
    // 50 MHz clock
    always #10 clk = ~clk;
    // control word: word sizes, word steps
    function automatic logic [31:0] cw(input logic [2:0] m, input int n, input logic [3:0] a);
        cw = {2'h2, DTC_SIZE_WORD, 2'h2, DTC_SIZE_WORD, 6'h00, a, 10'(n - 1), 1'b0, m};
    endfunction
    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task conclude;
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // bounded wait: 0 done pulse, 1 memory request, 2 word change, 3 bus answer
    task waitfor(input int w);
        k = 0;
        do
        begin
            @(posedge clk);
            k++;
        end
        while ((w == 0 ? chan_done[ch] : w == 1 ? mem_out.req : w == 2 ?
            i_mem.mem[cta] !== old : pready) !== 1'b1 && k < 3000);
        if (k >= 3000)
        begin
            fails++;
            $display("mismatch at %0t: wait ran out", $time);
            conclude;
        end
    endtask
    // one register bus transfer; result taken at the answering edge
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge clk);
        penable <= 1'b1;
        waitfor(3);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    // structure of channel ch at an aligned table base, random source words
    task setup(input logic alt, input logic [31:0] c, input int n);
        cta = 32'h1000 + (alt ? DTC_TBL_ALT_OFS : 32'h0) + ch * DTC_TBL_STRIDE;
        i_mem.mem[cta + DTC_SE_SRC] = 32'h4000 + ch * 256 + 4 * (n - 1);
        i_mem.mem[cta + DTC_SE_DST] = 32'h8000 + ch * 256 + 4 * (n - 1);
        i_mem.mem[cta + DTC_SE_CTL] = c;
        for (int i = 0; i < n; i++)
            i_mem.mem[32'h4000 + ch * 256 + 4 * i] = $random(seed);
        cta = cta + DTC_SE_CTL;
    endtask
    task chk_data(input int n);
        for (int i = 0; i < n; i++)
            chk(i_mem.mem[32'h8000 + ch * 256 + 4 * i], i_mem.mem[32'h4000 + ch * 256 + 4 * i]);
    endtask
    task start;
        apb(1'b1, DTC_OFS_EN_SET, 32'h1 << ch);
        apb(1'b1, DTC_OFS_SWREQ, 32'h1 << ch);
    endtask
    initial
    begin
        {clk, resetn, psel, penable, pwrite, slow, paddr, pwdata, req_single, req_burst} = '0;
        {seed, tests_run, fails} = {32'd92176, 64'd0};
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        apb(1'b0, 12'h030, 32'h0);
        chk({31'h0, err}, 32'h1);
        apb(1'b1, DTC_OFS_BASE, 32'h13FF);
        apb(1'b0, DTC_OFS_BASE, 32'h0);
        chk(rd, 32'h1000);
        // stop mode: nothing moved, channel switched off
        ch = {$random(seed)} % 8;
        setup(1'b0, cw(DTC_MODE_STOP, 4, 4'h0), 4);
        start;
        repeat (60) @(posedge clk);
        apb(1'b0, DTC_OFS_EN_SET, 32'h0);
        chk(rd, 32'h0);
        chk(32'(i_mem.mem.exists(32'h8000 + ch * 256)), 32'h0);
        // auto mode on slow memory from one momentary request
        ch = 8 + {$random(seed)} % 8;
        slow <= 1'b1;
        setup(1'b0, cw(DTC_MODE_AUTO, 5, 4'h1), 5);
        start;
        waitfor(0);
        chk(i_mem.mem[cta], cw(DTC_MODE_STOP, 1, 4'h1));
        chk(i_mem.mem[cta - 32'h8], 32'h4010 + ch * 256);
        chk_data(5);
        apb(1'b0, DTC_OFS_EN_SET, 32'h0);
        chk(rd, 32'h0);
        // fixed destination: every item lands on the end address itself
        ch = ch ^ 1;
        setup(1'b0, cw(DTC_MODE_AUTO, 3, 4'h1) | 32'hC000_0000, 3);
        start;
        waitfor(0);
        chk(i_mem.mem[32'h8008 + ch * 256], i_mem.mem[32'h4008 + ch * 256]);
        chk(32'(i_mem.mem.exists(32'h8000 + ch * 256)), 32'h0);
        // burst-only channel: singles ignored, bursts of min(2, remaining)
        ch = 16 + {$random(seed)} % 8;
        slow <= 1'b0;
        setup(1'b0, cw(DTC_MODE_BASIC, 5, 4'h1), 5);
        apb(1'b1, DTC_OFS_BO_SET, 32'h1 << ch);
        apb(1'b1, DTC_OFS_EN_SET, 32'h1 << ch);
        req_single <= 32'h1 << ch;
        repeat (60) @(posedge clk);
        chk(i_mem.mem[cta], cw(DTC_MODE_BASIC, 5, 4'h1));
        req_burst <= 32'h1 << ch;
        waitfor(1);
        req_burst <= 32'h0;
        old = i_mem.mem[cta];
        waitfor(2);
        chk(i_mem.mem[cta], cw(DTC_MODE_BASIC, 3, 4'h1));
        req_burst <= 32'h1 << ch;
        waitfor(0);
        {req_single, req_burst} <= '0;
        chk(i_mem.mem[cta], cw(DTC_MODE_STOP, 1, 4'h1));
        chk_data(5);
        // ping-pong: primary first, then alternate, channel stays on
        ch = 24 + {$random(seed)} % 8;
        setup(1'b1, cw(DTC_MODE_PP, 1, 4'h0), 1);
        setup(1'b0, cw(DTC_MODE_PP, 1, 4'h0), 1);
        start;
        waitfor(0);
        chk(i_mem.mem[cta], cw(DTC_MODE_STOP, 1, 4'h0));
        apb(1'b0, DTC_OFS_ALT, 32'h0);
        chk(rd, 32'h1 << ch);
        apb(1'b1, DTC_OFS_SWREQ, 32'h1 << ch);
        waitfor(0);
        chk(i_mem.mem[cta + DTC_TBL_ALT_OFS], cw(DTC_MODE_STOP, 1, 4'h0));
        apb(1'b0, DTC_OFS_EN_SET, 32'h0);
        chk(rd, 32'h1 << ch);
        apb(1'b1, DTC_OFS_EN_CLR, 32'h1 << ch);
        apb(1'b0, DTC_OFS_EN_SET, 32'h0);
        chk(rd, 32'h0);
        conclude;
    end
endmodule
